// ---- pkg/tweb_map.svh ----
// named constants of the two-wire memory bus slave
// assumes inclusion by the package and the core file only
`ifndef TWEB_MAP_SVH
`define TWEB_MAP_SVH

// word framing
`define TWEB_MSB 7
`define TWEB_WORD_LEN 4'h8
`define TWEB_CNT_ZERO 4'h0
`define TWEB_CNT_ONE 4'h1

// device address word layout
`define TWEB_CODE_HI 7
`define TWEB_CODE_LO 4
`define TWEB_DEV_CODE 4'ha
`define TWEB_RW_BIT 0

// buffering
`define TWEB_FIFO_DEPTH 4

`endif

// ---- pkg/tweb_pkg.sv ----
// types shared by the two-wire memory bus slave
// assumes the constants header is on the include path
`include "tweb_map.svh"

package tweb_pkg;

    // one byte on the wire
    typedef logic [`TWEB_MSB:0] tweb_byte_t;

    // received word handed to the memory side
    typedef struct packed {
        logic first;
        tweb_byte_t data;
    } tweb_wr_word_t;

    // bus phases
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_ADDR,
        PH_ACK,
        PH_RX,
        PH_TX,
        PH_MACK
    } tweb_phase_t;

    // whole state of the core
    typedef struct packed {
        logic [2:0] sclSync;
        logic [2:0] sdaSync;
        logic sclF;
        logic sdaF;
        tweb_phase_t phase;
        logic [3:0] bitCnt;
        tweb_byte_t shift;
        logic isRead;
        logic firstWord;
        logic gotData;
        logic hostNack;
        logic oeN;
        logic zeroDrv;
        logic standby;
        logic wrStart;
        logic txNext;
        logic pushValid;
        tweb_wr_word_t pushWord;
    } tweb_core_t;

endpackage

// ---- core/tweb_slave.sv ----
// two-wire serial memory bus slave: framing, shifting and acknowledge
// assumes pins arrive asynchronous, sda is open drain with a pull-up,
// and the memory side runs on core_clk
//
// Summary of operation
// [RULE1] data only changes while the clock is low
// [RULE2] a data edge with clock high is start or stop, never a bit
// [RULE3] a start begins every command; before it the bus is ignored
// [RULE4] a stop ends the current sequence
// [RULE5] a stop after a read returns the device to standby
// [RULE6] addresses and data move as 8-bit words, one bit per clock
// [RULE7] each received word is acknowledged low on the ninth clock; a data word that finds the buffer full gets no acknowledge
// [RULE8] standby at power-up and after stop once internal work ends
// [RULE9] controller recovers bus with up to 9 clocks then a start
// [RULE10] the data line is released unless a zero is driven
// [RULE11] the four top address bits must match the fixed pattern
// [RULE12] address bit zero high means read, low means write
// [RULE13] matching address is acknowledged, else back to standby
// [RULE14] no address acknowledge while an internal write runs
`timescale 1ns/1ps
`include "tweb_map.svh"

// ----------------------------------------------------------------
// shift-register fifo, head entry always at index zero
// ----------------------------------------------------------------
module tweb_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = `TWEB_FIFO_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // draining side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    typedef struct packed {
        logic [DEPTH:0] vld;
        logic [DEPTH:0][WIDTH-1:0] data;
    } tweb_fifo_st_t;

    tweb_fifo_st_t q;
    tweb_fifo_st_t d;
    logic pop;
    logic push;
    logic [DEPTH-1:0] nxtVld;
    logic [DEPTH-1:0][WIDTH-1:0] nxtData;

    // head and full taken straight from the entry flops
    assign inReady = !q.vld[DEPTH-1];
    assign outValid = q.vld[0];
    assign outData = q.data[0];
    assign pop = outReady && q.vld[0];
    assign push = inValid && inReady;

    // each entry shifts down on pop, the first free one takes a push
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        logic sv;
        logic svBelow;
        assign sv = pop ? q.vld[i+1] : q.vld[i];
        if (i == 0) begin : g_head
            assign svBelow = 1'b1;
        end else begin : g_tail
            assign svBelow = pop ? q.vld[i] : q.vld[i-1];
        end
        assign nxtVld[i] = sv || (push && svBelow);
        assign nxtData[i] = (push && svBelow && !sv) ? inData :
                            (pop ? q.data[i+1] : q.data[i]);
    end

    // gather entries; the spare top slot stays empty
    always_comb begin
        d = q;
        d.vld = {1'b0, nxtVld};
        d.data = {{WIDTH{1'b0}}, nxtData};
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// ----------------------------------------------------------------
// bus slave core
// ----------------------------------------------------------------
module tweb_slave
    import tweb_pkg::*;
#(
    parameter int FIFO_DEPTH = `TWEB_FIFO_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // two-wire pins
    input wire logic sclPin,
    input wire logic sdaPin,
    output logic sdaDrive,
    output logic sdaOeN,
    // memory side, read data
    input wire tweb_byte_t txByte,
    output logic txNext,
    // memory side, received words
    output tweb_wr_word_t rxWord,
    output logic rxValid,
    input wire logic rxReady,
    // memory side, write cycle
    input wire logic writeBusy,
    output logic writeStart,
    output logic standby
);
    tweb_core_t q;
    tweb_core_t d;
    logic sclNew;
    logic sdaNew;
    logic sclRise;
    logic sclFall;
    logic startEv;
    logic stopEv;
    logic addrDone;
    logic addrMatch;
    logic pushReady;
    logic wordDone;
    logic loadTx;

    // --------------------------------------------------------------
    // pin filter and events
    // --------------------------------------------------------------
    // a level counts only once the 2nd and 3rd flops agree
    assign sclNew = (q.sclSync[1] == q.sclSync[2]) ? q.sclSync[2] : q.sclF;
    assign sdaNew = (q.sdaSync[1] == q.sdaSync[2]) ? q.sdaSync[2] : q.sdaF;
    assign sclRise = sclNew && !q.sclF;
    assign sclFall = !sclNew && q.sclF;
    // data edges with clock held high are framing only
    assign startEv = q.sclF && sclNew && q.sdaF && !sdaNew; // [RULE2]
    assign stopEv = q.sclF && sclNew && !q.sdaF && sdaNew; // [RULE2]
    assign wordDone = sclFall && (q.bitCnt == `TWEB_WORD_LEN);
    assign addrDone = wordDone && (q.phase == PH_ADDR);
    assign addrMatch =
        (q.shift[`TWEB_CODE_HI:`TWEB_CODE_LO] == `TWEB_DEV_CODE);

    // --------------------------------------------------------------
    // received word buffer
    // --------------------------------------------------------------
    // a full buffer makes the core refuse the word with no acknowledge
    tweb_fifo #(
        .WIDTH($bits(tweb_wr_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .srst(srst),
        .inValid(q.pushValid),
        .inReady(pushReady),
        .inData(q.pushWord),
        .outValid(rxValid),
        .outReady(rxReady),
        .outData(rxWord)
    );

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        d = q;
        loadTx = 1'b0;
        d.sclSync = {q.sclSync[1:0], sclPin};
        d.sdaSync = {q.sdaSync[1:0], sdaPin};
        d.sclF = sclNew;
        d.sdaF = sdaNew;
        d.wrStart = 1'b0;
        d.txNext = 1'b0;
        if (q.pushValid && pushReady) begin
            d.pushValid = 1'b0;
        end
        // idle with no write pending is standby
        d.standby = (q.phase == PH_IDLE) && !writeBusy && !q.wrStart; // [RULE8]
        if (stopEv) begin
            // only a stop after written data launches the write cycle
            d.wrStart = !q.isRead && q.gotData; // [RULE4] [RULE8]
            d.phase = PH_IDLE; // [RULE4] [RULE5]
            d.oeN = 1'b1;
            d.gotData = 1'b0;
        end else if (startEv) begin
            // repeated start is legal from any phase
            d.phase = PH_ADDR; // [RULE3]
            d.bitCnt = `TWEB_CNT_ZERO;
            d.oeN = 1'b1;
            d.gotData = 1'b0;
        end else if (sclRise) begin
            // sample on the rising edge, data is stable while high
            unique case (q.phase)
                PH_ADDR, PH_RX: begin
                    d.shift = {q.shift[`TWEB_MSB-1:0], q.sdaF}; // [RULE6]
                    d.bitCnt = q.bitCnt + `TWEB_CNT_ONE;
                end
                PH_TX: begin
                    d.bitCnt = q.bitCnt + `TWEB_CNT_ONE; // [RULE6]
                end
                PH_MACK: begin
                    d.hostNack = q.sdaF;
                end
                PH_IDLE, PH_ACK: begin
                end
            endcase
        end else if (sclFall) begin
            // drive changes only just after the falling edge
            unique case (q.phase)
                PH_ADDR: begin
                    if (addrDone) begin
                        if (addrMatch && !writeBusy) begin // [RULE11] [RULE14]
                            d.oeN = 1'b0; // [RULE13]
                            d.isRead = q.shift[`TWEB_RW_BIT]; // [RULE12]
                            d.firstWord = 1'b1;
                            d.phase = PH_ACK;
                        end else begin
                            d.phase = PH_IDLE; // [RULE13]
                        end
                    end
                end
                PH_RX: begin
                    if (wordDone) begin
                        if (!q.pushValid && pushReady) begin
                            d.pushValid = 1'b1;
                            d.pushWord = {q.firstWord, q.shift};
                            d.gotData = q.gotData || !q.firstWord;
                            d.firstWord = 1'b0;
                            d.oeN = 1'b0; // [RULE7]
                            d.phase = PH_ACK;
                        end else begin
                            d.phase = PH_IDLE;
                        end
                    end
                end
                PH_ACK: begin
                    d.oeN = 1'b1; // [RULE10]
                    d.bitCnt = `TWEB_CNT_ZERO;
                    if (q.isRead) begin
                        loadTx = 1'b1;
                    end else begin
                        d.phase = PH_RX;
                    end
                end
                PH_TX: begin
                    if (wordDone) begin
                        d.oeN = 1'b1; // [RULE10]
                        d.phase = PH_MACK;
                    end else begin
                        d.shift = {q.shift[`TWEB_MSB-1:0], 1'b0};
                        d.oeN = q.shift[`TWEB_MSB-1]; // [RULE10]
                    end
                end
                PH_MACK: begin
                    // host acknowledge asks for the next byte
                    if (!q.hostNack) begin
                        d.bitCnt = `TWEB_CNT_ZERO;
                        loadTx = 1'b1;
                    end else begin
                        d.phase = PH_IDLE;
                    end
                end
                PH_IDLE: begin
                end
            endcase
        end
        // put the next read byte on the wire, msb first
        if (loadTx) begin
            d.shift = txByte;
            d.oeN = txByte[`TWEB_MSB]; // [RULE1] [RULE10]
            d.txNext = 1'b1;
            d.phase = PH_TX;
        end
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------
    // pins reset to released so power-up never holds the bus
    always_ff @(posedge core_clk) begin
        if (srst) begin
            q <= '0;
            q.sclSync <= 3'h7;
            q.sdaSync <= 3'h7;
            q.sclF <= 1'b1;
            q.sdaF <= 1'b1;
            q.phase <= PH_IDLE;
            q.oeN <= 1'b1;
            q.standby <= 1'b1; // [RULE8]
        end else begin
            q <= d;
        end
    end

    // outputs are flops of the state
    assign sdaDrive = q.zeroDrv;
    assign sdaOeN = q.oeN;
    assign txNext = q.txNext;
    assign writeStart = q.wrStart;
    assign standby = q.standby;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    property p_stable_drive;
        $changed(q.oeN) |-> !q.sclF;
    endproperty
    a_stable_drive: assert property (p_stable_drive) // [RULE1]
        else $error("data drive changed with clock high");

    property p_frame_no_bit;
        (startEv || stopEv) |=> (q.shift == $past(q.shift));
    endproperty
    a_frame_no_bit: assert property (p_frame_no_bit) // [RULE2]
        else $error("framing edge shifted as a data bit");

    property p_start_addr;
        startEv |=> (q.phase == PH_ADDR) && (q.bitCnt == 4'h0);
    endproperty
    a_start_addr: assert property (p_start_addr) // [RULE3]
        else $error("start did not open address phase");

    property p_stop_idle;
        stopEv |=> (q.phase == PH_IDLE) && q.oeN;
    endproperty
    a_stop_idle: assert property (p_stop_idle) // [RULE4]
        else $error("stop did not end the sequence");

    property p_read_standby;
        (stopEv && q.isRead) ##1 !writeBusy |=> q.standby;
    endproperty
    a_read_standby: assert property (p_read_standby) // [RULE5]
        else $error("no standby after read stop");

    property p_word_len;
        q.bitCnt <= 4'h8;
    endproperty
    a_word_len: assert property (p_word_len) // [RULE6]
        else $error("bit count beyond one word");

    property p_data_ack;
        (wordDone && q.phase == PH_RX && !q.pushValid && pushReady)
            |=> !q.oeN && (q.phase == PH_ACK);
    endproperty
    a_data_ack: assert property (p_data_ack) // [RULE7]
        else $error("received word not acknowledged");

    property p_idle_standby;
        (q.phase == PH_IDLE && !writeBusy && !q.wrStart) |=> q.standby;
    endproperty
    a_idle_standby: assert property (p_idle_standby) // [RULE8]
        else $error("idle without standby");

    property p_release;
        !q.oeN |-> (q.phase inside {PH_ACK, PH_TX});
    endproperty
    a_release: assert property (p_release) // [RULE10]
        else $error("data line held outside ack or send");

    property p_bad_code;
        (addrDone && !addrMatch) |=> (q.phase == PH_IDLE) && q.oeN;
    endproperty
    a_bad_code: assert property (p_bad_code) // [RULE11]
        else $error("foreign address answered");

    property p_dir_ack;
        (addrDone && addrMatch && !writeBusy) |=> !q.oeN &&
            (q.isRead == $past(q.shift[`TWEB_RW_BIT]));
    endproperty
    a_dir_ack: assert property (p_dir_ack) // [RULE12]
        else $error("address ack or direction wrong");

    property p_busy_nack;
        (addrDone && writeBusy) |=> q.oeN ##1 q.oeN;
    endproperty
    a_busy_nack: assert property (p_busy_nack) // [RULE14]
        else $error("address acknowledged during write");
endmodule

// ---- dv/tweb_ctrl_model.sv ----
// bus controller model for the two-wire memory slave bench
// assumes a pull-up on the data wire and the caller resolving it
`timescale 1ns/1ps

// ----------------------------------------------------------------
// controller: clock stands high between frames, data is open drain
// ----------------------------------------------------------------
module tweb_ctrl_model
    import tweb_pkg::*;
(
    // link pins
    output logic sclOut,
    output logic sdaOeN,
    input wire logic sdaWire
);
    // low half is longer so slave data settles before the rise
    localparam int LOW_Q = 150;
    localparam int HIGH_Q = 125;

    // bus idle: clock high, data released
    initial begin
        sclOut = 1'b1;
        sdaOeN = 1'b1;
    end

    // data falls while clock high
    task automatic start_cond();
        #LOW_Q sdaOeN = 1'b1;
        #LOW_Q sclOut = 1'b1;
        #HIGH_Q sdaOeN = 1'b0;
        #HIGH_Q sclOut = 1'b0;
    endtask

    // data rises while clock high
    task automatic stop_cond();
        #LOW_Q sdaOeN = 1'b0;
        #LOW_Q sclOut = 1'b1;
        #HIGH_Q sdaOeN = 1'b1;
        #HIGH_Q;
    endtask

    // data changes mid-low only, sampled mid-high
    task automatic bit_cycle(input logic b, output logic seen);
        #LOW_Q sdaOeN = b;
        #LOW_Q sclOut = 1'b1;
        #HIGH_Q seen = sdaWire;
        #HIGH_Q sclOut = 1'b0;
    endtask

    // eight bits msb first, ninth clock reads the acknowledge
    task automatic send_byte(input tweb_byte_t d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(d[i], s);
        end
        bit_cycle(1'b1, s);
        ack = ~s;
    endtask

    // read a word, then acknowledge or not on the ninth clock
    task automatic recv_byte(input logic hostAck, output tweb_byte_t d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, d[i]);
        end
        bit_cycle(~hostAck, s);
    endtask

    // nine released clocks counting high data, then a start
    task automatic recover(output int highs);
        logic s;
        highs = 0;
        repeat (9) begin
            bit_cycle(1'b1, s);
            highs += (s === 1'b1);
        end
        start_cond();
    endtask
endmodule

// ---- dv/testbench.sv ----
// self-checking bench of the two-wire memory bus slave
// assumes the controller model and a pulled-up data wire
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
    miscompares++; \
    $display("wrong value at %0t: %h vs %h", $time, a, b); end end

module testbench;
    import tweb_pkg::*;
    logic core_clk, srst, sdaDrive, sdaOeN, ctrlOeN, txNext, rxValid;
    logic rxReady, writeBusy, writeStart, standby, sclPin, sdaPin;
    tweb_byte_t txByte;
    tweb_wr_word_t rxWord;
    int miscompares, tests_run, cycles, busyLeft, writeCount;

    // pull-up: any enabled driver pulls the wire low
    assign sdaPin = ((!sdaOeN && !sdaDrive) || !ctrlOeN) ? 1'b0 : 1'b1;

    tweb_slave #(.FIFO_DEPTH(4)) tweb_slave_i (.core_clk(core_clk),
        .srst(srst), .sclPin(sclPin), .sdaPin(sdaPin),
        .sdaDrive(sdaDrive), .sdaOeN(sdaOeN), .txByte(txByte),
        .txNext(txNext), .rxWord(rxWord), .rxValid(rxValid),
        .rxReady(rxReady), .writeBusy(writeBusy),
        .writeStart(writeStart), .standby(standby));
    tweb_ctrl_model ctrl_i (.sclOut(sclPin), .sdaOeN(ctrlOeN),
        .sdaWire(sdaPin));

    // ------------------------------------------------------------
    // memory side: write time, read data and the hang guard
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        #1;
        if (writeStart === 1'b1) begin
            writeCount++;
            busyLeft = 300;
        end
        writeBusy = (busyLeft > 0);
        if (busyLeft > 0) busyLeft--;
        if (txNext === 1'b1) txByte = txByte + 8'h11;
        cycles++;
        if (cycles > 40000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // bounded wait for the head word, then pop it
    task automatic pop_check(input tweb_wr_word_t exp);
        int n;
        n = 0;
        while (rxValid !== 1'b1 && n < 200) begin
            @(posedge core_clk) #1;
            n++;
        end
        `CHK(rxWord, exp)
        rxReady = 1'b1;
        @(posedge core_clk) #1 rxReady = 1'b0;
        @(posedge core_clk) #1;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_ignore_recover();
        logic ack;
        int highs;
        ctrl_i.send_byte(8'ha0, ack);
        `CHK(ack, 1'b0)
        ctrl_i.recover(highs);
        `CHK(highs, 9)
        ctrl_i.send_byte(8'ha0, ack);
        `CHK(ack, 1'b1)
        ctrl_i.stop_cond();
    endtask

    task automatic t_write_poll();
        logic ack;
        ctrl_i.start_cond();
        ctrl_i.send_byte(8'ha0, ack);
        `CHK(ack, 1'b1)
        ctrl_i.send_byte(8'h3c, ack);
        `CHK(ack, 1'b1)
        ctrl_i.send_byte(8'h5a, ack);
        `CHK(ack, 1'b1)
        ctrl_i.stop_cond();
        repeat (20) @(posedge core_clk);
        #1;
        `CHK(writeCount, 1)
        `CHK(standby, 1'b0)
        pop_check({1'b1, 8'h3c});
        pop_check({1'b0, 8'h5a});
        ctrl_i.start_cond();
        ctrl_i.send_byte(8'ha0, ack);
        `CHK(ack, 1'b0)
        ctrl_i.stop_cond();
        // pins move off the sampling edge, never on it
        while (writeBusy === 1'b1) @(posedge core_clk);
        #1;
        ctrl_i.start_cond();
        ctrl_i.send_byte(8'ha0, ack);
        `CHK(ack, 1'b1)
        ctrl_i.stop_cond();
        repeat (6) @(posedge core_clk);
        #1;
        `CHK(standby, 1'b1)
    endtask

    task automatic t_bad_addr();
        logic ack;
        ctrl_i.start_cond();
        ctrl_i.send_byte(8'h50, ack);
        `CHK(ack, 1'b0)
        `CHK(standby, 1'b1)
        ctrl_i.stop_cond();
    endtask

    // start inside a data word, then a read of two words
    task automatic t_restart_read();
        logic ack, s;
        tweb_byte_t d, t0;
        ctrl_i.start_cond();
        ctrl_i.send_byte(8'ha0, ack);
        ctrl_i.send_byte(8'h3c, ack);
        repeat (4) ctrl_i.bit_cycle(1'b0, s);
        ctrl_i.start_cond();
        t0 = txByte;
        ctrl_i.send_byte(8'ha1, ack);
        `CHK(ack, 1'b1)
        ctrl_i.recv_byte(1'b1, d);
        `CHK(d, t0)
        ctrl_i.recv_byte(1'b0, d);
        `CHK(d, t0 + 8'h11)
        ctrl_i.stop_cond();
        repeat (6) @(posedge core_clk);
        #1;
        `CHK(standby, 1'b1)
        `CHK(writeCount, 1)
        pop_check({1'b1, 8'h3c});
        `CHK(rxValid, 1'b0)
    endtask

    // memory side stalls: fifo fills and the fifth word is refused
    task automatic t_fifo_full();
        logic ack;
        ctrl_i.start_cond();
        ctrl_i.send_byte(8'ha0, ack);
        for (int k = 0; k < 5; k++) begin
            ctrl_i.send_byte(8'h10 + 8'h11 * k, ack);
            `CHK(ack, (k < 4))
        end
        ctrl_i.stop_cond();
        for (int k = 0; k < 4; k++) begin
            // the byte is sized so the first flag lands in bit 8
            pop_check({(k == 0), 8'(8'h10 + 8'h11 * k)});
        end
        `CHK(rxValid, 1'b0)
        while (writeBusy === 1'b1) @(posedge core_clk);
        #1;
    endtask

    // ------------------------------------------------------------
    // clock, reset and main sequence
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    initial begin
        srst = 1'b1;
        rxReady = 1'b0;
        txByte = 8'hc3;
        writeBusy = 1'b0;
        busyLeft = 0;
        repeat (10) @(posedge core_clk);
        #1 srst = 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        `CHK(standby, 1'b1)
        `CHK(sdaOeN, 1'b1)
        `CHK(rxValid, 1'b0)
        #13;
        t_ignore_recover();
        t_write_poll();
        t_bad_addr();
        t_restart_read();
        t_fifo_full();
        tally_and_finish();
    end
endmodule
